// file: logic/cmss_pkg.sv
// Package: register map, field codes and constants of the mode and setpoint select block
package cmss_pkg;
   // Register byte offsets
   localparam logic [7:0] CMSS_CFG_OFF     = 8'h00;
   localparam logic [7:0] CMSS_YMAN_OFF    = 8'h04;
   localparam logic [7:0] CMSS_YREP_OFF    = 8'h08;
   localparam logic [7:0] CMSS_SEL_OFF     = 8'h0C;
   localparam logic [7:0] CMSS_SP0_OFF     = 8'h10;
   localparam logic [7:0] CMSS_STAT_OFF    = 8'h20;
   localparam logic [7:0] CMSS_YOUT_OFF    = 8'h24;
   localparam logic [7:0] CMSS_YAUTO_OFF   = 8'h28;

   // CFG field positions
   localparam int CFG_TYPE_LSB   = 0;
   localparam int CFG_DIR_BIT    = 3;
   localparam int CFG_MANEN_BIT  = 4;
   localparam int CFG_MANSRC_BIT = 5;
   localparam int CFG_ERRSRC_BIT = 6;
   localparam int CFG_BTN_BIT    = 7;
   localparam int CFG_INIT_BIT   = 8;
   localparam int CFG_PVSRC_BIT  = 9;
   localparam int CFG_SPSRC_BIT  = 10;
   localparam int CFG_PAIR_BIT   = 11;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   // Output level limits, percent
   localparam logic signed [7:0] Y_MAX = 8'sd100;
   localparam logic signed [7:0] Y_MIN = -8'sd100;
   localparam logic signed [7:0] Y_RST = 8'sd0;

   typedef enum logic [2:0] {
      CMSS_TYPE_OFF   = 3'b000,
      CMSS_TYPE_TWO   = 3'b001,
      CMSS_TYPE_THREE = 3'b010,
      CMSS_TYPE_STEP  = 3'b011,
      CMSS_TYPE_CONT  = 3'b100
   } cmss_ctype_type;

   typedef enum logic [1:0] {
      CMSS_ST_INIT = 2'b00,
      CMSS_ST_AUTO = 2'b01,
      CMSS_ST_MAN  = 2'b10,
      CMSS_ST_ERR  = 2'b11
   } cmss_state_type;

   // Clamp a signed byte to -100..+100
   function automatic logic signed [7:0] cmss_clamp(input logic signed [7:0] v);
      if (v > Y_MAX) return Y_MAX;
      if (v < Y_MIN) return Y_MIN;
      return v;
   endfunction
endpackage

// file: logic/cmss_setpoint_sel.sv
// Setpoint select: picks one of four setpoints from two select bits
module cmss_setpoint_sel
   import cmss_pkg::*;
#(
   parameter int W = 16
) (
   // Selection
   input  wire logic [1:0]         sel_i,
   input  wire logic [4*W-1:0]     sp_i,
   // Result
   output logic      [W-1:0]       sp_o
);
   always_comb begin
      sp_o = sp_i[sel_i*W +: W];
   end
endmodule // cmss_setpoint_sel

// file: logic/cmss_out_drive.sv
// Output drive: maps output level to switched and continuous outputs per controller type
module cmss_out_drive
   import cmss_pkg::*;
(
   // Control
   input  wire logic [2:0]         ctype_i,
   input  wire logic               pair_cont_i,
   input  wire logic               hold_i,
   input  wire logic signed [7:0]  y_i,
   // Outputs
   output logic      [1:0]         sw_o,
   output logic signed [7:0]       cont_o
);
   always_comb begin
      sw_o   = 2'b00;
      cont_o = Y_RST;
      case (cmss_ctype_type'(ctype_i))
         CMSS_TYPE_OFF: begin
            sw_o = 2'b00;
         end
         CMSS_TYPE_TWO: begin
            sw_o[0] = (y_i > 8'sd0);
         end
         CMSS_TYPE_THREE: begin
            if (pair_cont_i) begin
               cont_o  = (y_i > 8'sd0) ? y_i : Y_RST;
               sw_o[1] = (y_i < 8'sd0);
            end else begin
               sw_o[0] = (y_i > 8'sd0);
               sw_o[1] = (y_i < 8'sd0);
            end
         end
         CMSS_TYPE_STEP: begin
            // Held value stops the actuator; 0 closes, positive opens
            if (!hold_i) begin
               sw_o[0] = (y_i > 8'sd0);
               sw_o[1] = (y_i <= 8'sd0);
            end
         end
         CMSS_TYPE_CONT: begin
            cont_o = y_i;
         end
         default: begin
            sw_o = 2'b00;
         end
      endcase
   end
endmodule // cmss_out_drive

// file: logic/cmss_ctrl.sv
// Controller mode and setpoint selection top with APB register file
//
// Chosen here: the APB interface to the registers and the register offsets.
module cmss_ctrl
   import cmss_pkg::*;
#(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic                clk_sys_i,
   input  wire logic                reset_n_i,
   // APB slave
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [7:0]          paddr_i,
   input  wire logic [31:0]         pwdata_i,
   output logic      [31:0]         prdata_o,
   output logic                     pready_o,
   output logic                     pslverr_o,
   // Digital control inputs
   input  wire logic [1:0]          sp_sel_i,
   input  wire logic                man_req_i,
   input  wire logic                man_inh_i,
   input  wire logic                pblk_i,
   input  wire logic                ctrl_on_i,
   input  wire logic                ctrl_off_i,
   // Analog values
   input  wire logic signed [W-1:0] pv_analog_i,
   input  wire logic signed [W-1:0] pv_alt_i,
   input  wire logic signed [W-1:0] sp_ext_i,
   input  wire logic                range_fault_i,
   input  wire logic signed [7:0]   y_ctrl_i,
   // Outputs
   output logic      [1:0]          sw_o,
   output logic signed [7:0]        cont_o,
   output logic                     pblk2_o,
   output logic signed [W-1:0]      pv_o,
   output logic signed [W-1:0]      sp_o
);
   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic        [31:0]      cfg_q, cfg_d;
   logic signed [7:0]       yman_q, yman_d;
   logic signed [7:0]       yrep_q, yrep_d;
   logic        [5:0]       sel_q, sel_d;
   logic        [4*W-1:0]   sp_q, sp_d;
   logic                    wr_en;
   logic                    btn_clr;

   assign wr_en     = psel_i & penable_i & pwrite_i;
   assign pready_o  = 1'b1;

   always_comb begin
      cfg_d  = cfg_q;
      yman_d = yman_q;
      yrep_d = yrep_q;
      sel_d  = sel_q;
      sp_d   = sp_q;
      if (btn_clr) begin
         cfg_d[CFG_BTN_BIT] = 1'b0;
      end
      if (wr_en) begin
         case (paddr_i)
            CMSS_CFG_OFF:  cfg_d  = pwdata_i;
            CMSS_YMAN_OFF: yman_d = cmss_clamp(pwdata_i[7:0]);
            CMSS_YREP_OFF: yrep_d = cmss_clamp(pwdata_i[7:0]);
            CMSS_SEL_OFF:  sel_d  = pwdata_i[5:0];
            default: begin
               if (paddr_i[7:4] == CMSS_SP0_OFF[7:4] && paddr_i[1:0] == 2'b00) begin
                  sp_d[paddr_i[3:2]*W +: W] = pwdata_i[W-1:0];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         cfg_q  <= CFG_RESET;
         yman_q <= Y_RST;
         yrep_q <= Y_RST;
         sel_q  <= '0;
         sp_q   <= '0;
      end else begin
         cfg_q  <= cfg_d;
         yman_q <= yman_d;
         yrep_q <= yrep_d;
         sel_q  <= sel_d;
         sp_q   <= sp_d;
      end
   end

   // ------------------------------------------------------------
   // Digital selector assignment
   // ------------------------------------------------------------
   // SEL bits: 0 sp bit0, 1 sp bit1, 2 manual, 3 inhibit, 4 pblock, 5 on/off
   logic [1:0] sp_bits;
   logic       man_sig, inh_sig, pblk_sig, on_sig, off_sig;
   always_comb begin
      sp_bits  = sp_sel_i & sel_q[1:0];
      man_sig  = man_req_i & sel_q[2];
      inh_sig  = man_inh_i & sel_q[3];
      pblk_sig = pblk_i & sel_q[4];
      on_sig   = ctrl_on_i & sel_q[5];
      off_sig  = ctrl_off_i & sel_q[5];
   end
   assign pblk2_o = pblk_sig;

   // ------------------------------------------------------------
   // Setpoint and actual value sources
   // ------------------------------------------------------------
   logic [W-1:0] sp_act;
   cmss_setpoint_sel #(.W(W)) u_spsel (
      .sel_i (sp_bits),
      .sp_i  (sp_q),
      .sp_o  (sp_act)
   );

   logic signed [W-1:0] pv_d, sp_s_d, pv_r, sp_r;
   always_comb begin
      pv_d   = cfg_q[CFG_PVSRC_BIT] ? pv_alt_i : pv_analog_i;
      sp_s_d = cfg_q[CFG_SPSRC_BIT] ? sp_ext_i : signed'(sp_act);
   end

   // ------------------------------------------------------------
   // Run enable and mode state machine
   // ------------------------------------------------------------
   logic           run_q, run_d;
   cmss_state_type st_q, st_d;
   logic signed [7:0] y_q, y_d, yhold_q, yhold_d, yauto;
   logic           hold_q, hold_d;
   logic           man_ok, man_want;

   always_comb begin
      run_d = run_q;
      if (off_sig) begin
         run_d = 1'b0;
      end else if (on_sig) begin
         run_d = 1'b1;
      end
   end

   // Direction: controller level assumes direct; inverse flips its sign
   always_comb begin
      yauto = cfg_q[CFG_DIR_BIT] ? cmss_clamp(-y_ctrl_i) : cmss_clamp(y_ctrl_i);
   end

   assign man_ok   = cfg_q[CFG_MANEN_BIT] & ~inh_sig;
   assign man_want = man_sig | cfg_q[CFG_BTN_BIT];
   assign btn_clr  = (st_q == CMSS_ST_MAN) & ~man_sig & ~man_ok;

   always_comb begin
      st_d    = st_q;
      y_d     = y_q;
      yhold_d = yhold_q;
      hold_d  = hold_q;
      case (st_q)
         CMSS_ST_INIT: begin
            y_d    = Y_RST;
            hold_d = 1'b0;
            if (cfg_q[CFG_INIT_BIT]) begin
               st_d = CMSS_ST_AUTO;
            end
         end
         CMSS_ST_AUTO: begin
            y_d     = yauto;
            yhold_d = yauto;
            hold_d  = 1'b0;
            if (range_fault_i) begin
               st_d   = CMSS_ST_ERR;
               hold_d = ~cfg_q[CFG_ERRSRC_BIT];
               y_d    = cfg_q[CFG_ERRSRC_BIT] ? yrep_q : y_q;
            end else if (man_want && man_ok) begin
               st_d   = CMSS_ST_MAN;
               hold_d = ~cfg_q[CFG_MANSRC_BIT];
               y_d    = cfg_q[CFG_MANSRC_BIT] ? yman_q : y_q;
            end
         end
         CMSS_ST_MAN: begin
            // Hold follows the source setting so a configured level drives the actuator
            hold_d = ~cfg_q[CFG_MANSRC_BIT];
            if (cfg_q[CFG_MANSRC_BIT]) begin
               y_d = yman_q;
            end
            if (!man_want || !cfg_q[CFG_MANEN_BIT]) begin
               st_d = CMSS_ST_AUTO;
            end
         end
         CMSS_ST_ERR: begin
            hold_d = ~cfg_q[CFG_ERRSRC_BIT];
            if (cfg_q[CFG_ERRSRC_BIT]) begin
               y_d = yrep_q;
            end
            if (!range_fault_i) begin
               st_d = CMSS_ST_AUTO;
            end
         end
         default: begin
            st_d = CMSS_ST_INIT;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         run_q   <= 1'b0;
         st_q    <= CMSS_ST_INIT;
         y_q     <= Y_RST;
         yhold_q <= Y_RST;
         hold_q  <= 1'b0;
         pv_r    <= '0;
         sp_r    <= '0;
      end else begin
         run_q   <= run_d;
         st_q    <= st_d;
         y_q     <= y_d;
         yhold_q <= yhold_d;
         hold_q  <= hold_d;
         pv_r    <= pv_d;
         sp_r    <= sp_s_d;
      end
   end
   assign pv_o = pv_r;
   assign sp_o = sp_r;

   // ------------------------------------------------------------
   // Output drive
   // ------------------------------------------------------------
   logic [2:0]        type_eff;
   logic [1:0]        sw_c;
   logic signed [7:0] cont_c;
   logic              live;
   assign live     = run_q & (st_q != CMSS_ST_INIT);
   assign type_eff = live ? cfg_q[CFG_TYPE_LSB +: 3] : 3'(CMSS_TYPE_OFF);

   cmss_out_drive u_drv (
      .ctype_i     (type_eff),
      .pair_cont_i (cfg_q[CFG_PAIR_BIT]),
      .hold_i      (hold_q),
      .y_i         (y_q),
      .sw_o        (sw_c),
      .cont_o      (cont_c)
   );

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         sw_o   <= 2'b00;
         cont_o <= Y_RST;
      end else begin
         sw_o   <= sw_c;
         cont_o <= cont_c;
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   logic [31:0] rd_c;
   always_comb begin
      rd_c = 32'h0000_0000;
      case (paddr_i)
         CMSS_CFG_OFF:   rd_c = cfg_q;
         CMSS_YMAN_OFF:  rd_c = 32'(yman_q);
         CMSS_YREP_OFF:  rd_c = 32'(yrep_q);
         CMSS_SEL_OFF:   rd_c = {26'h0, sel_q};
         CMSS_STAT_OFF:  rd_c = {25'h0, pblk_sig, hold_q, run_q, sw_c, st_q};
         CMSS_YOUT_OFF:  rd_c = 32'(y_q);
         CMSS_YAUTO_OFF: rd_c = 32'(yhold_q);
         default: begin
            if (paddr_i[7:4] == CMSS_SP0_OFF[7:4] && paddr_i[1:0] == 2'b00) begin
               rd_c = 32'(sp_q[paddr_i[3:2]*W +: W]);
            end
         end
      endcase
   end
   assign prdata_o  = rd_c;
   assign pslverr_o = 1'b0;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_fault_entry;
      st_q == CMSS_ST_AUTO && range_fault_i && cfg_q[CFG_ERRSRC_BIT];
   endsequence

   a_init_quiet: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      st_q == CMSS_ST_INIT |=> sw_o == 2'b00 && cont_o == Y_RST)
      else $error("outputs active during init");
   a_off_wins: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      off_sig |=> !run_q)
      else $error("off request not honoured");
   a_on_sets: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      on_sig && !off_sig |=> run_q)
      else $error("on request not honoured");
   a_man_inh: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      st_q == CMSS_ST_AUTO && !man_ok |=> st_q != CMSS_ST_MAN)
      else $error("manual entered while inhibited");
   a_fault_rep: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      s_fault_entry |=> st_q == CMSS_ST_ERR && y_q == $past(yrep_q))
      else $error("fault replacement level wrong");
   a_yman_range: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      yman_q <= Y_MAX && yman_q >= Y_MIN && yrep_q <= Y_MAX && yrep_q >= Y_MIN)
      else $error("manual level out of range");
   a_type_off: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      !run_q ##1 !run_q |-> sw_o == 2'b00)
      else $error("switched output active while off");
   a_two_one: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      type_eff == 3'(CMSS_TYPE_TWO) |=> !sw_o[1])
      else $error("two-state drove second output");
   a_sp_pick: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      !cfg_q[CFG_SPSRC_BIT] |=> sp_o == $past(sp_act))
      else $error("setpoint selection wrong");

   sequence s_man_entry_cfg;
      st_q == CMSS_ST_AUTO && !range_fault_i && man_want && man_ok && cfg_q[CFG_MANSRC_BIT];
   endsequence

   a_man_level: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      s_man_entry_cfg |=> st_q == CMSS_ST_MAN && y_q == $past(yman_q))
      else $error("manual entry level wrong");
   a_step_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      hold_q && type_eff == 3'(CMSS_TYPE_STEP) |=> sw_o == 2'b00)
      else $error("step actuator moved while held");
   a_cont_only: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      type_eff == 3'(CMSS_TYPE_CONT) |=> sw_o == 2'b00)
      else $error("continuous type drove a switched output");
endmodule // cmss_ctrl

// file: verif/cmss_plant.sv
// Plant model: digital contacts, sensor values and a motor actuator
module cmss_plant
   import cmss_pkg::*;
(
   // Clock
   input  wire logic               clk_sys_i,
   // Requests from the bench
   input  wire logic [7:0]         dig_i,
   input  wire logic signed [15:0] pv_i,
   input  wire logic signed [7:0]  y_i,
   // Actuator drive
   input  wire logic [1:0]         sw_i,
   // Pins toward the controller; pos_o is the actuator position for the bench
   output logic      [7:0]         dig_o,
   output logic signed [15:0]      pv_o,
   output logic signed [7:0]       y_o,
   output int                      pos_o
);
   always @(posedge clk_sys_i) begin
      dig_o <= dig_i;
      pv_o  <= pv_i;
      y_o   <= y_i;
      if (sw_i == 2'b01) begin
         pos_o <= pos_o + 1;
      end else if (sw_i == 2'b10) begin
         pos_o <= pos_o - 1;
      end
   end
endmodule // cmss_plant

// file: verif/tb.sv
// Bench: APB register access, digital control and output drive checks
module tb
   import cmss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   //----------------------------------------
   // Signals
   //----------------------------------------
   logic               clk_sys = 1'b0;
   logic               reset_n = 1'b0;
   logic               psel    = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite  = 1'b0;
   logic        [7:0]  paddr   = 8'h00;
   logic        [31:0] pwdata  = 32'h0000_0000;
   logic        [31:0] prdata;
   logic        [31:0] rd;
   logic               rd_err;
   logic               pready;
   logic               pslverr;
   logic        [7:0]  dig     = 8'h00;
   logic        [7:0]  dig_pin;
   logic signed [15:0] pv_cmd  = 16'h0123;
   logic signed [15:0] pv_alt  = 16'h0456;
   logic signed [15:0] sp_ext  = 16'h0789;
   logic signed [15:0] pv_pin;
   logic signed [7:0]  y_cmd   = 8'h32;
   logic signed [7:0]  y_pin;
   logic        [1:0]  sw;
   logic signed [7:0]  cont;
   logic               pblk2;
   logic signed [15:0] pv;
   logic signed [15:0] sp;
   int                 pos;
   int                 p0;
   int                 n_fail     = 0;
   int                 num_checks = 0;
   logic [31:0] t_cfg [9] = '{32'h0000_0100, 32'h0000_0101, 32'h0000_0102, 32'h0000_0102,
      32'h0000_0902, 32'h0000_0103, 32'h0000_0103, 32'h0000_0104, 32'h0000_010C};
   logic [7:0]  t_y   [9] = '{8'h32, 8'h32, 8'h32, 8'hCE, 8'h32, 8'h32, 8'hCE, 8'h32, 8'h32};
   logic [1:0]  t_sw  [9] = '{2'b00, 2'b01, 2'b01, 2'b10, 2'b00, 2'b01, 2'b10, 2'b00, 2'b00};
   logic [7:0]  t_ct  [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h32, 8'h00, 8'h00, 8'h32, 8'hCE};

   always #2 clk_sys = ~clk_sys;
   //----------------------------------------
   // Instances
   //----------------------------------------
   cmss_plant plant (.clk_sys_i(clk_sys), .dig_i(dig), .pv_i(pv_cmd), .y_i(y_cmd),
      .sw_i(sw), .dig_o(dig_pin), .pv_o(pv_pin), .y_o(y_pin), .pos_o(pos));

   cmss_ctrl #(.W(16)) dut (.clk_sys_i(clk_sys), .reset_n_i(reset_n), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .sp_sel_i(dig_pin[1:0]),
      .man_req_i(dig_pin[2]), .man_inh_i(dig_pin[3]), .pblk_i(dig_pin[4]),
      .ctrl_on_i(dig_pin[5]), .ctrl_off_i(dig_pin[6]), .pv_analog_i(pv_pin),
      .pv_alt_i(pv_alt), .sp_ext_i(sp_ext), .range_fault_i(dig_pin[7]), .y_ctrl_i(y_pin),
      .sw_o(sw), .cont_o(cont), .pblk2_o(pblk2), .pv_o(pv), .sp_o(sp));
   //----------------------------------------
   // Tasks
   //----------------------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         n_fail++;
         report_and_stop();
      end
      rd = prdata;
      rd_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
      apb(1'b0, a, 32'h0000_0000);
      check(what, e, rd & m);
   endtask

   task automatic settle();
      repeat (4) @(posedge clk_sys);
   endtask

   task automatic cfg(input logic [31:0] v);
      wr(CMSS_CFG_OFF, v);
      settle();
   endtask
   //----------------------------------------
   // Sequence
   //----------------------------------------
   initial begin
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      rdchk(CMSS_CFG_OFF, 32'hFFFF_FFFF, CFG_RESET, "cfg reset");
      rdchk(CMSS_YMAN_OFF, 32'h0000_00FF, 32'h0000_0000, "yman reset");
      rdchk(CMSS_YREP_OFF, 32'h0000_00FF, 32'h0000_0000, "yrep reset");
      rdchk(8'h2C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
      check("unmapped slverr", 32'h0, {31'h0, rd_err});
      wr(CMSS_YMAN_OFF, 32'h0000_0078);
      rdchk(CMSS_YMAN_OFF, 32'h0000_00FF, 32'h0000_0064, "yman clamp");
      wr(CMSS_YREP_OFF, 32'hFFFF_FF80);
      rdchk(CMSS_YREP_OFF, 32'h0000_00FF, 32'h0000_009C, "yrep clamp");
      // Switched on, initialisation not yet finished
      wr(CMSS_SEL_OFF, 32'h0000_0020);
      dig <= 8'h20;
      cfg(32'h0000_0004);
      check("init sw", 32'h0, {30'h0, sw});
      check("init cont", 32'h0, {24'h00_0000, cont});
      rdchk(CMSS_STAT_OFF, 32'h3, 32'h0, "init state");
      for (int i = 0; i < 9; i++) begin
         y_cmd <= t_y[i];
         cfg(t_cfg[i]);
         check("type sw", {30'h0, t_sw[i]}, {30'h0, sw});
         check("type cont", {24'h00_0000, t_ct[i]}, {24'h00_0000, cont});
      end
      rdchk(CMSS_STAT_OFF, 32'h10, 32'h10, "run on");
      dig <= 8'h40;
      settle();
      rdchk(CMSS_STAT_OFF, 32'h10, 32'h0, "run off");
      check("off cont", 32'h0, {24'h00_0000, cont});
      dig <= 8'h20;
      settle();
      dig <= 8'h60;
      settle();
      rdchk(CMSS_STAT_OFF, 32'h10, 32'h0, "on and off");
      dig <= 8'h20;
      settle();
      rdchk(CMSS_STAT_OFF, 32'h10, 32'h10, "run again");
      // Setpoints, parameter block, sources
      for (int i = 0; i < 4; i++)
         wr(CMSS_SP0_OFF + 8'(4 * i), 32'h0000_0A00 + 32'(i));
      wr(CMSS_SEL_OFF, 32'h0000_0033);
      for (int i = 0; i < 4; i++) begin
         dig <= 8'h20 | 8'(i);
         settle();
         check("setpoint", 32'h0000_0A00 + 32'(i), {16'h0000, sp});
      end
      dig <= 8'h30;
      settle();
      check("pblock on", 32'h1, {31'h0, pblk2});
      wr(CMSS_SEL_OFF, 32'h0000_0020);
      dig <= 8'h33;
      settle();
      check("unassigned sp", 32'h0000_0A00, {16'h0000, sp});
      check("unassigned pblock", 32'h0, {31'h0, pblk2});
      check("pv analog", 32'h0000_0123, {16'h0000, pv});
      cfg(32'h0000_0704);
      check("pv alt", 32'h0000_0456, {16'h0000, pv});
      check("sp ext", 32'h0000_0789, {16'h0000, sp});
      // Manual mode
      wr(CMSS_SEL_OFF, 32'h0000_002C);
      dig <= 8'h24;
      cfg(32'h0000_0113);
      rdchk(CMSS_STAT_OFF, 32'h3, 32'h2, "manual entry");
      check("step held", 32'h0, {30'h0, sw});
      cfg(32'h0000_0133);
      p0 = pos;
      check("step open", 32'h1, {30'h0, sw});
      rdchk(CMSS_YOUT_OFF, 32'h0000_00FF, 32'h0000_0064, "manual level");
      settle();
      check("actuator moves", 32'h1, {31'h0, pos > p0});
      wr(CMSS_YMAN_OFF, 32'h0000_0000);
      settle();
      check("step close", 32'h2, {30'h0, sw});
      dig <= 8'h2C;
      cfg(32'h0000_0103);
      cfg(32'h0000_0113);
      rdchk(CMSS_STAT_OFF, 32'h3, 32'h1, "inhibit");
      dig <= 8'h24;
      settle();
      rdchk(CMSS_STAT_OFF, 32'h3, 32'h2, "inhibit gone");
      cfg(32'h0000_0103);
      rdchk(CMSS_STAT_OFF, 32'h3, 32'h1, "manual refused");
      wr(CMSS_SEL_OFF, 32'h0000_0020);
      cfg(32'h0000_0113);
      rdchk(CMSS_STAT_OFF, 32'h3, 32'h1, "unassigned manual");
      cfg(32'h0000_01B3);
      rdchk(CMSS_STAT_OFF, 32'h3, 32'h2, "button manual");
      // Range fault
      dig <= 8'h20;
      y_cmd <= 8'h32;
      cfg(32'h0000_0144);
      dig <= 8'hA0;
      settle();
      check("fault repl", 32'h0000_009C, {24'h00_0000, cont});
      rdchk(CMSS_STAT_OFF, 32'h3, 32'h3, "fault state");
      dig <= 8'h20;
      cfg(32'h0000_0104);
      dig <= 8'hA0;
      settle();
      y_cmd <= 8'h14;
      settle();
      check("fault held", 32'h0000_0032, {24'h00_0000, cont});
      report_and_stop();
   end
endmodule // tb
